// ### hdl/pcpg_defs.svh
/*
  Register offsets, field positions, reset values and timing figures of the
  clock and power-good configuration block.
  Assumes it is included by bare name and that the includer owns the scope.
*/
`ifndef PCPG_DEFS_SVH
`define PCPG_DEFS_SVH
`define PCPG_ADDR_CONFIG     8'h13
`define PCPG_ADDR_PLL        8'h14
`define PCPG_ADDR_PGC1       8'h15
`define PCPG_ADDR_PGC2       8'h16
`define PCPG_ADDR_FAULT      8'h17
`define PCPG_ADDR_INT        8'h19
`define PCPG_RST_BYTE        8'h00
`define PCPG_CFG_STARTUP_SEL 6
`define PCPG_CFG_SHUTDN_SEL  5
`define PCPG_CFG_PIN_SEL     4
`define PCPG_CFG_PIN_PD      3
`define PCPG_CFG_ENABLE_PIN_PULLDOWN_ENABLE       2
`define PCPG_CFG_TWARN_LVL   1
`define PCPG_CFG_SPREAD      0
`define PCPG_PLL_EN          6
`define PCPG_FREQ_MSB        4
`define PCPG_FREQ_LSB        0
`define PCPG_FREQ_CODE_MAX   5'h17
`define PCPG_PG1_POL         7
`define PCPG_PG1_OD          6
`define PCPG_PG1_WIN_LIN     5
`define PCPG_PG1_WIN_SW      4
`define PCPG_SRC_MSB         3
`define PCPG_SRC_LSB         0
`define PCPG_PG2_TWARN       2
`define PCPG_PG2_FAULT_GATE  1
`define PCPG_PG2_MODE        0
`define PCPG_INT_PG_DROP     7
`define PCPG_INT_CLK_CHANGE  4
`define PCPG_CLK_MHZ         25
`define PCPG_STEP_SHORT_US   500
`define PCPG_STEP_LONG_US    1000
`define PCPG_STEP_CNT_W      15
`endif

// ### hdl/pcpg_pkg.sv
/*
  Types shared by the clock and power-good configuration block.
  Assumes nothing of its surroundings.
*/
package pcpg_pkg;
  typedef logic [7:0] pcpg_byte_t;
  typedef logic [3:0] pcpg_src_t;
  typedef logic [4:0] pcpg_freq_t;
endpackage : pcpg_pkg

// ### hdl/pcpg_config.sv
/*
  Configuration registers for delay ranges, shared clock pin, thermal
  warning level, spread spectrum, PLL and power-good output, with the
  power-good evaluation, fault latch and the two event status bits.
  Assumes the serial interface decodes each access into one-cycle write
  and read strobes with an address, all synchronous to CLK.
*/
// Notes on behaviour
// R1: Startup delay step is 0.5 ms when range select is 0, 1 ms when 1.
// R2: Shutdown delay step is 0.5 ms when range select is 0, 1 ms when 1.
// R3: Pin function select routes shared pin to second output (0) or clock (1).
// R4: Shared pin pull-down follows its select bit in either pin function.
// R5: Enable pin pull-down follows its select bit.
// R6: Thermal warning threshold is 125 C when 0, 137 C when 1.
// R7: Spread spectrum is off when 0 and on when 1.
// R8: PLL bit 0 forces the internal oscillator and keeps the PLL off.
// R9: PLL bit 1 runs PLL when on and uses external clock when present.
// R10: With PLL on, external clock appearing or vanishing raises an event.
// R11: Software keeps bit 5 of the PLL register at 0.
// R12: Frequency code plus one gives MHz; codes above 0x17 are reserved.
// R13: Polarity 0 drives valid high, polarity 1 drives valid low.
// R14: Output type 0 is push-pull, 1 is open-drain.
// R15: Linear regulator window bit adds overvoltage check when 1.
// R16: Switcher window bit adds overvoltage check when 1.
// R17: Four source bits include each source in monitoring when 1.
// R18: Thermal gating bit forces power-good inactive during thermal warning.
// R19: Fault gating bit makes power-good follow the fault latch.
// R20: Mode bit selects gated (0) or continuous (1) operation.
// R21: Fault latch sets on an enabled failing source; write-1 clears if valid.
// R22: Power-good going active to inactive sets a write-1-clear status bit.
// R23: Power-good is valid only when all enabled sources are valid.
// R24: Reserved bits read back what was written, reset to zero, no effect. The interrupt register's reserved bits read zero.
`timescale 1ns/1ps
`include "pcpg_defs.svh"
module pcpg_config #(
  parameter int STEP_SHORT_CYC = `PCPG_STEP_SHORT_US * `PCPG_CLK_MHZ,
  parameter int STEP_LONG_CYC  = `PCPG_STEP_LONG_US * `PCPG_CLK_MHZ
) (
  input  wire logic               CLK,
  input  wire logic               RST_N,
  input  wire logic [7:0]         REG_ADDR,
  input  wire pcpg_pkg::pcpg_byte_t REG_WDATA,
  input  wire logic               REG_WR,
  input  wire logic               REG_RD,
  output pcpg_pkg::pcpg_byte_t    REG_RDATA,
  input  wire pcpg_pkg::pcpg_src_t UV_OK,
  input  wire pcpg_pkg::pcpg_src_t OV_OK,
  input  wire logic               THERMAL_WARN,
  input  wire logic               EXT_CLK_DETECT,
  input  wire logic               DEV_RUN,
  output logic                    SHARED_PIN_CLOCK_FN,
  output logic                    SHARED_PIN_PULLDOWN,
  output logic                    ENABLE_PIN_PULLDOWN,
  output logic                    THERMAL_THRESH_HIGH,
  output logic                    SPREAD_SPECTRUM_EN,
  output logic                    PLL_ENABLE,
  output logic                    CLK_SRC_EXTERNAL,
  output pcpg_pkg::pcpg_freq_t    EXTERNAL_CLOCK_FREQUENCY_CODE_CODE,
  output logic                    STARTUP_STEP_TICK,
  output logic                    SHUTDOWN_STEP_TICK,
  output logic                    POWER_GOOD_O,
  output logic                    POWER_GOOD_OE
);
  import pcpg_pkg::*;

  // Source window check, shared by the live evaluation and the clear guard.
  function automatic logic src_ok(input logic uv, input logic ov,
                                  input logic win);
    src_ok = uv & (ov | ~win);
  endfunction : src_ok

  pcpg_byte_t config_ff;
  pcpg_byte_t pll_ff;
  pcpg_byte_t pgc1_ff;
  pcpg_byte_t pgc2_ff;
  pcpg_byte_t fault_ff;
  logic       drop_int_ff;
  logic       clk_int_ff;
  pcpg_byte_t rdata_ff;
  logic       ext_present_ff;
  logic       pg_active_ff;
  logic       pg_o_ff;
  logic       pg_oe_ff;
  logic       pll_run_ff;
  logic       clk_ext_ff;
  pcpg_src_t  src_valid;
  pcpg_src_t  src_en;
  pcpg_src_t  fault_set;
  logic       live_good;
  logic       nxt_pg_active;
  logic       ext_present;
  logic       wr_fault;
  logic       wr_int;
  logic [1:0] tick_ff;

  assign wr_fault = REG_WR && (REG_ADDR == `PCPG_ADDR_FAULT);
  assign wr_int   = REG_WR && (REG_ADDR == `PCPG_ADDR_INT);
  assign src_en   = pgc1_ff[`PCPG_SRC_MSB:`PCPG_SRC_LSB]; // R17

  // Plain read/write configuration bytes; reserved bits are kept as written.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      config_ff <= `PCPG_RST_BYTE; // R24
      pll_ff    <= `PCPG_RST_BYTE;
      pgc1_ff   <= `PCPG_RST_BYTE;
      pgc2_ff   <= `PCPG_RST_BYTE;
    end
    else if (REG_WR)
    begin
      unique case (REG_ADDR)
        `PCPG_ADDR_CONFIG: config_ff <= REG_WDATA; // R24
        `PCPG_ADDR_PLL:    pll_ff    <= REG_WDATA; // R11
        `PCPG_ADDR_PGC1:   pgc1_ff   <= REG_WDATA;
        `PCPG_ADDR_PGC2:   pgc2_ff   <= REG_WDATA;
        default:           ;
      endcase
    end
  end

  // Read data is registered, so it appears one cycle after the strobe.
  // Unmapped offsets answer zero.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      rdata_ff <= `PCPG_RST_BYTE;
    else if (REG_RD)
    begin
      unique case (REG_ADDR)
        `PCPG_ADDR_CONFIG: rdata_ff <= config_ff;
        `PCPG_ADDR_PLL:    rdata_ff <= pll_ff;
        `PCPG_ADDR_PGC1:   rdata_ff <= pgc1_ff;
        `PCPG_ADDR_PGC2:   rdata_ff <= pgc2_ff;
        `PCPG_ADDR_FAULT:  rdata_ff <= fault_ff;
        `PCPG_ADDR_INT:
        begin
          rdata_ff <= `PCPG_RST_BYTE;
          rdata_ff[`PCPG_INT_PG_DROP]    <= drop_int_ff;
          rdata_ff[`PCPG_INT_CLK_CHANGE] <= clk_int_ff;
        end
        default:           rdata_ff <= `PCPG_RST_BYTE;
      endcase
    end
  end
  assign REG_RDATA = rdata_ff;

  // Pin and analog selects are straight register bits.
  assign SHARED_PIN_CLOCK_FN = config_ff[`PCPG_CFG_PIN_SEL];   // R3
  assign SHARED_PIN_PULLDOWN = config_ff[`PCPG_CFG_PIN_PD];    // R4
  assign ENABLE_PIN_PULLDOWN = config_ff[`PCPG_CFG_ENABLE_PIN_PULLDOWN_ENABLE];     // R5
  assign THERMAL_THRESH_HIGH = config_ff[`PCPG_CFG_TWARN_LVL]; // R6
  assign SPREAD_SPECTRUM_EN  = config_ff[`PCPG_CFG_SPREAD];    // R7
  assign EXTERNAL_CLOCK_FREQUENCY_CODE_CODE   = pll_ff[`PCPG_FREQ_MSB:`PCPG_FREQ_LSB];

  // Step dividers for the delay sequencer; one per direction.
  // The count restarts whenever its range changes so no step is cut short.
  for (genvar g = 0; g < 2; g++)
  begin : g_step
    logic [`PCPG_STEP_CNT_W-1:0] cnt_ff;
    logic                        sel_ff;
    logic                        sel;
    logic [`PCPG_STEP_CNT_W-1:0] lim;
    assign sel = (g == 0) ? config_ff[`PCPG_CFG_STARTUP_SEL]
                          : config_ff[`PCPG_CFG_SHUTDN_SEL];
    assign lim = sel ? `PCPG_STEP_CNT_W'(STEP_LONG_CYC - 1)
                     : `PCPG_STEP_CNT_W'(STEP_SHORT_CYC - 1); // R1 R2
    always_ff @(posedge CLK)
    begin
      if (!RST_N)
      begin
        cnt_ff     <= '0;
        sel_ff     <= 1'b0;
        tick_ff[g] <= 1'b0;
      end
      else
      begin
        sel_ff <= sel;
        if (sel != sel_ff || cnt_ff == lim)
          cnt_ff <= '0;
        else
          cnt_ff <= cnt_ff + 1'b1;
        tick_ff[g] <= (sel == sel_ff) && (cnt_ff == lim); // R1 R2
      end
    end
  end
  assign STARTUP_STEP_TICK  = tick_ff[0];
  assign SHUTDOWN_STEP_TICK = tick_ff[1];

  // An external clock only counts when the pin is in clock function and the
  // programmed frequency is a legal code; a reserved code keeps the RC.
  assign ext_present = EXT_CLK_DETECT && config_ff[`PCPG_CFG_PIN_SEL]
                    && (EXTERNAL_CLOCK_FREQUENCY_CODE_CODE <= `PCPG_FREQ_CODE_MAX); // R12

  // PLL enable and switching clock source.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      pll_run_ff     <= 1'b0;
      clk_ext_ff     <= 1'b0;
      ext_present_ff <= 1'b0;
    end
    else
    begin
      pll_run_ff     <= pll_ff[`PCPG_PLL_EN] && DEV_RUN;   // R8 R9
      clk_ext_ff     <= pll_ff[`PCPG_PLL_EN] && DEV_RUN
                     && ext_present;                      // R8 R9
      ext_present_ff <= ext_present;
    end
  end
  assign PLL_ENABLE       = pll_run_ff;
  assign CLK_SRC_EXTERNAL = clk_ext_ff;

  // Per-source validity and fault latch bits.
  for (genvar s = 0; s < 4; s++)
  begin : g_src
    logic win;
    assign win = (s >= 2) ? pgc1_ff[`PCPG_PG1_WIN_LIN]          // R15
                          : pgc1_ff[`PCPG_PG1_WIN_SW];          // R16
    assign src_valid[s] = src_ok(UV_OK[s], OV_OK[s], win);
    assign fault_set[s] = src_en[s] && !src_valid[s];           // R21
    always_ff @(posedge CLK)
    begin
      if (!RST_N)
        fault_ff[s] <= 1'b0;
      else if (fault_set[s])
        fault_ff[s] <= 1'b1; // R21
      else if (wr_fault && REG_WDATA[s] && src_valid[s])
        fault_ff[s] <= 1'b0; // R21
    end
  end

  // Reserved upper bits of the fault register hold what software wrote.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      fault_ff[7:4] <= 4'h0;
    else if (wr_fault)
      fault_ff[7:4] <= REG_WDATA[7:4]; // R24
  end

  // Combined condition; disabled sources are masked out of the live check, but latched fault bits are not.
  always_comb
  begin
    live_good = &(src_valid | ~src_en); // R23
    if (pgc2_ff[`PCPG_PG2_FAULT_GATE])
      nxt_pg_active = ~|(fault_ff[`PCPG_SRC_MSB:`PCPG_SRC_LSB]
                         | fault_set); // R19
    else
      nxt_pg_active = live_good; // R19
    if (pgc2_ff[`PCPG_PG2_TWARN] && THERMAL_WARN)
      nxt_pg_active = 1'b0; // R18
    if (!pgc2_ff[`PCPG_PG2_MODE] && !DEV_RUN)
      nxt_pg_active = 1'b0; // R20
  end

  // Pin drive. Open-drain only ever pulls low, so a high level is left to
  // the external pull-up with the enable released.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      pg_active_ff <= 1'b0;
      pg_o_ff      <= 1'b0;
      pg_oe_ff     <= 1'b0;
    end
    else
    begin
      pg_active_ff <= nxt_pg_active;
      if (pgc1_ff[`PCPG_PG1_OD])
      begin
        pg_o_ff  <= 1'b0; // R14
        pg_oe_ff <= ~(nxt_pg_active ^ pgc1_ff[`PCPG_PG1_POL]); // R13 R14
      end
      else
      begin
        pg_o_ff  <= nxt_pg_active ^ pgc1_ff[`PCPG_PG1_POL]; // R13
        pg_oe_ff <= 1'b1; // R14
      end
    end
  end
  assign POWER_GOOD_O  = pg_o_ff;
  assign POWER_GOOD_OE = pg_oe_ff;

  // Event status bits; a new event in the clearing cycle wins.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      drop_int_ff <= 1'b0;
      clk_int_ff  <= 1'b0;
    end
    else
    begin
      if (pg_active_ff && !nxt_pg_active)
        drop_int_ff <= 1'b1; // R22
      else if (wr_int && REG_WDATA[`PCPG_INT_PG_DROP])
        drop_int_ff <= 1'b0; // R22
      if (pll_ff[`PCPG_PLL_EN] && (ext_present != ext_present_ff))
        clk_int_ff <= 1'b1; // R10
      else if (wr_int && REG_WDATA[`PCPG_INT_CLK_CHANGE])
        clk_int_ff <= 1'b0;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  chk_fault_sets: assert property ( // R21
    fault_set[0] |=> fault_ff[0])
    else $error("fault bit did not latch");
  chk_fault_hold: assert property ( // R21
    fault_ff[0] && !src_valid[0] && wr_fault |=> fault_ff[0])
    else $error("fault bit cleared while source invalid");
  chk_pg_polarity: assert property ( // R13
    !pgc1_ff[`PCPG_PG1_OD] |=> POWER_GOOD_OE
    && (POWER_GOOD_O == (pg_active_ff ^ $past(pgc1_ff[`PCPG_PG1_POL]))))
    else $error("push-pull level wrong for polarity");
  chk_od_no_high: assert property ( // R14
    pgc1_ff[`PCPG_PG1_OD] && $stable(pgc1_ff) |=> !POWER_GOOD_O)
    else $error("open-drain drove high");
  chk_twarn_gates: assert property ( // R18
    pgc2_ff[`PCPG_PG2_TWARN] && THERMAL_WARN |=> !pg_active_ff)
    else $error("power-good active during thermal warning");
  chk_drop_flag: assert property ( // R22
    $fell(pg_active_ff) |-> drop_int_ff)
    else $error("drop event not latched");
  chk_pll_off: assert property ( // R8
    !pll_ff[`PCPG_PLL_EN] [*2] |-> !PLL_ENABLE && !CLK_SRC_EXTERNAL)
    else $error("PLL or external clock used while disabled");
  chk_clk_event: assert property ( // R10
    pll_ff[`PCPG_PLL_EN] && $changed(ext_present) |=> clk_int_ff)
    else $error("clock change event missed");
  chk_tick_space: assert property ( // R1
    STARTUP_STEP_TICK |=> !STARTUP_STEP_TICK [*8])
    else $error("startup step ticks too close");
  chk_masked_src: assert property ( // R23
    src_en == 4'h0 && !pgc2_ff[`PCPG_PG2_FAULT_GATE]
    && !(pgc2_ff[`PCPG_PG2_TWARN] && THERMAL_WARN)
    && (pgc2_ff[`PCPG_PG2_MODE] || DEV_RUN) |=> pg_active_ff)
    else $error("power-good inactive with no source enabled");

  cov_pg_drop:   cover property ($fell(pg_active_ff));
  cov_clk_event: cover property ($rose(clk_int_ff));
  cov_fault_clr: cover property ($fell(fault_ff[0]));
endmodule : pcpg_config

// ### testbench/pcpg_host.sv
/*
  Host model that issues single-byte register writes and reads.
  Assumes the block takes a strobe on the rising edge of CLK.
*/
`timescale 1ns/1ps
module pcpg_host (
  input  wire logic       CLK,
  input  wire logic [7:0] REG_RDATA,
  output logic      [7:0] REG_ADDR,
  output logic      [7:0] REG_WDATA,
  output logic            REG_WR,
  output logic            REG_RD
);
  // The bus is idle from time zero so nothing is taken during reset.
  initial
  begin
    REG_ADDR  = 8'h00;
    REG_WDATA = 8'h00;
    REG_WR    = 1'b0;
    REG_RD    = 1'b0;
  end

  // Released lines show inverted values, so stale data cannot pass.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLK);
    REG_ADDR  = a;
    REG_WDATA = (a == 8'h14) ? (d & 8'hdf) : d;
    REG_WR    = 1'b1;
    @(negedge CLK);
    REG_WR    = 1'b0;
    REG_ADDR  = ~a;
    REG_WDATA = ~d;
  endtask : wr

  // Read data is taken one cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(negedge CLK);
    REG_ADDR = a;
    REG_RD   = 1'b1;
    @(negedge CLK);
    REG_RD   = 1'b0;
    REG_ADDR = ~a;
    q        = REG_RDATA;
  endtask : rd
endmodule : pcpg_host

// ### testbench/pmic_clock_power_good_output_config_tb.sv
/*
  Self-checking bench for the clock and power-good configuration block.
  Assumes the host model and the block share one 25 MHz clock.
*/
`timescale 1ns/1ps
module pmic_clock_power_good_output_config_tb;
  import pcpg_pkg::*;
  localparam int SHORT = 10;
  localparam int LONG  = 20;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  pcpg_byte_t addr, wdata, rdata, q;
  logic       wr, rd, twarn, det, run, pin_fn, pin_pd, enable_pin_pulldown_enable, thr_hi, ss;
  logic       pll, ext, st_tick, sd_tick, pg_o, pg_oe;
  pcpg_src_t  uv, ov;
  pcpg_freq_t fcode;
  int         err_count = 0;
  int         check_count = 0;
  int         cyc = 0;
  int         s, d;

  // A 40 ns clock period.
  always #20 clk = ~clk;

  pcpg_config #(.STEP_SHORT_CYC(SHORT), .STEP_LONG_CYC(LONG)) u_dut (
    .CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .UV_OK(uv), .OV_OK(ov),
    .THERMAL_WARN(twarn), .EXT_CLK_DETECT(det), .DEV_RUN(run),
    .SHARED_PIN_CLOCK_FN(pin_fn), .SHARED_PIN_PULLDOWN(pin_pd),
    .ENABLE_PIN_PULLDOWN(enable_pin_pulldown_enable), .THERMAL_THRESH_HIGH(thr_hi),
    .SPREAD_SPECTRUM_EN(ss), .PLL_ENABLE(pll), .CLK_SRC_EXTERNAL(ext),
    .EXTERNAL_CLOCK_FREQUENCY_CODE_CODE(fcode), .STARTUP_STEP_TICK(st_tick),
    .SHUTDOWN_STEP_TICK(sd_tick), .POWER_GOOD_O(pg_o),
    .POWER_GOOD_OE(pg_oe));

  pcpg_host u_host (.CLK(clk), .REG_RDATA(rdata), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, q);
    chk($sformatf("register %h", a), e, q);
  endtask : rc

  // Pins are sampled three falling edges after a write lands.
  task automatic ws(input logic [7:0] a, input logic [7:0] v);
    u_host.wr(a, v);
    repeat (2) @(negedge clk);
  endtask : ws

  task automatic pg(input logic o, input logic e);
    repeat (2) @(negedge clk);
    chk("power good pins", {6'h0, o, e}, {6'h0, pg_o, pg_oe});
  endtask : pg

  task automatic pc(input logic [7:0] e);
    chk("pll pins", e, {6'h0, pll, ext});
  endtask : pc

  // A hang is cut short well above the expected run length.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_count++;
      stop_test();
    end
  end

  initial
  begin
    {uv, ov, twarn, det, run} = {8'hff, 3'h0};
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    for (int a = 8'h13; a <= 8'h17; a++)
      rc(8'(a), 8'h00);
    u_host.wr(8'h20, 8'h5a);
    rc(8'h20, 8'h00);
    for (int b = 0; b < 5; b++)
    begin
      ws(8'h13, 8'h80 | 8'(1 << b));
      chk("config pins", 8'(1 << b),
          {3'h0, pin_fn, pin_pd, enable_pin_pulldown_enable, thr_hi, ss});
    end
    rc(8'h13, 8'h90);
    for (int m = 0; m < 4; m++)
    begin
      ws(8'h13, 8'h10 | 8'(m << 5));
      {s, d} = 0;
      repeat (40) @(negedge clk)
      begin
        s += st_tick;
        d += sd_tick;
      end
      chk("startup ticks", 8'(40 / (m[1] ? LONG : SHORT)), 8'(s));
      chk("shutdown ticks", 8'(40 / (m[0] ? LONG : SHORT)), 8'(d));
    end
    ws(8'h13, 8'h10);
    {run, det} = 2'b11;
    ws(8'h14, 8'h17);
    pc(8'h00);
    ws(8'h19, 8'hff);
    det = 1'b0;
    ws(8'h19, 8'h00);
    det = 1'b1;
    ws(8'h19, 8'h00);
    rc(8'h19, 8'h00);
    ws(8'h14, 8'h77);
    pc(8'h03);
    chk("freq code", 8'h17, {3'h0, fcode});
    rc(8'h14, 8'h57);
    ws(8'h19, 8'hff);
    det = 1'b0;
    ws(8'h19, 8'h00);
    pc(8'h02);
    rc(8'h19, 8'h10);
    ws(8'h19, 8'hff);
    det = 1'b1;
    ws(8'h19, 8'h00);
    rc(8'h19, 8'h10);
    ws(8'h19, 8'hff);
    run = 1'b0;
    ws(8'h19, 8'h00);
    pc(8'h00);
    u_host.rd(8'h19, q);
    chk("drop event", 8'h80, q & 8'h80);
    ws(8'h19, 8'hff);
    rc(8'h19, 8'h00);
    run = 1'b1;
    ws(8'h14, 8'h40);
    chk("freq code low", 8'h00, {3'h0, fcode});
    pc(8'h03);
    ws(8'h16, 8'hf9);
    rc(8'h16, 8'hf9);
    for (int w = 0; w < 2; w++)
    begin
      ov = w ? 4'hc : 4'h3;
      ws(8'h15, w ? 8'h2f : 8'h1f);
      pg(1'b1, 1'b1);
      ws(8'h15, w ? 8'h1f : 8'h2f);
      pg(1'b0, 1'b1);
    end
    ov = 4'hf;
    for (int i = 0; i < 4; i++)
    begin
      uv = ~(4'h1 << i);
      ws(8'h15, 8'h0f & ~(8'h1 << i));
      pg(1'b1, 1'b1);
      ws(8'h15, 8'h0f);
      pg(1'b0, 1'b1);
      uv = 4'hf;
    end
    rc(8'h17, 8'h0f);
    ws(8'h16, 8'h03);
    pg(1'b0, 1'b1);
    uv = 4'he;
    u_host.wr(8'h17, 8'hff);
    rc(8'h17, 8'hf1);
    uv = 4'hf;
    u_host.wr(8'h17, 8'hf1);
    rc(8'h17, 8'hf0);
    pg(1'b1, 1'b1);
    ws(8'h16, 8'h05);
    twarn = 1'b1;
    pg(1'b0, 1'b1);
    ws(8'h16, 8'h01);
    pg(1'b1, 1'b1);
    twarn = 1'b0;
    run = 1'b0;
    pg(1'b1, 1'b1);
    ws(8'h16, 8'h00);
    pg(1'b0, 1'b1);
    run = 1'b1;
    pg(1'b1, 1'b1);
    ws(8'h15, 8'h8f);
    pg(1'b0, 1'b1);
    ws(8'h15, 8'h4f);
    pg(1'b0, 1'b0);
    uv = 4'he;
    pg(1'b0, 1'b1);
    stop_test();
  end
endmodule : pmic_clock_power_good_output_config_tb
